/* common/spw_defs.svh */
// register map, field positions and reset values of the pwm timebase
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH

// byte offsets on the register bus, one 32-bit word each
`define SPW_OFS_PWM_CONTROL      8'h00
`define SPW_OFS_DUTY_MSB_BYTE    8'h04
`define SPW_OFS_DUTY_ACTIVE_BYTE 8'h08
`define SPW_OFS_TIMER_SELECT     8'h0c
`define SPW_OFS_PERIOD_LIMIT     8'h10
`define SPW_OFS_TIMEBASE_CONTROL 8'h14
`define SPW_OFS_TIMEBASE_COUNT   8'h18
`define SPW_OFS_STATUS           8'h1c
`define SPW_OFS_PIN_DIRECTION    8'h20

// pwm_control fields
`define SPW_CTRL_LSB_HI   5
`define SPW_CTRL_LSB_LO   4
`define SPW_CTRL_MODE_HI  3
`define SPW_CTRL_MODE_LO  0
`define SPW_MODE_OFF      4'h0
`define SPW_MODE_PWM_TOP  2'h3

// timebase_control fields
`define SPW_TCTRL_POST_HI 6
`define SPW_TCTRL_POST_LO 3
`define SPW_TCTRL_RUN     2
`define SPW_TCTRL_PRE_HI  1
`define SPW_TCTRL_PRE_LO  0

// status fields
`define SPW_STAT_FLAG     0
`define SPW_STAT_SLEEP    1

// last prescaler count per setting: 4, 16, 64, 256 system clocks
`define SPW_PC_LAST_1     8'h03
`define SPW_PC_LAST_4     8'h0f
`define SPW_PC_LAST_16    8'h3f
`define SPW_PC_LAST_64    8'hff

// reset values
`define SPW_RST_CTRL      6'h00
`define SPW_RST_BYTE      8'h00
`define SPW_RST_PERIOD    8'hff
`define SPW_RST_TCTRL     7'h00
`define SPW_RST_PIN_DIR   1'b1

`endif

/* common/spw_pkg.sv */
// types of the standard pwm timebase
`default_nettype none
package spw_pkg;

    typedef enum logic [1:0] {
        spw_pre_1,
        spw_pre_4,
        spw_pre_16,
        spw_pre_64
    } spw_prescale_t;

    typedef struct packed {
        logic       ack;       // bus answer phase
        logic [7:0] rdata;     // captured read byte
        logic [5:0] ctrl;      // duty_lsb_pair and mode_select
        logic [7:0] duty_msb;  // duty_msb_byte
        logic [7:0] duty_act;  // duty_active_byte
        logic [1:0] lsb_latch; // buffered duty low bits
        logic [7:0] tsel;      // timer_select
        logic [7:0] period;    // period_limit
        logic [6:0] tctrl;     // timebase_control
        logic [7:0] count;     // timebase_count
        logic [7:0] pc;        // system clock prescaler
        logic       flag;      // timebase_match_flag
        logic       pin_dir;   // pin_direction, 1 = input
        logic       pin_lvl;   // pwm output latch
        logic [2:0] sync;      // sleep synchroniser
        logic       sleep;     // filtered sleep level
    } spw_state_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } spw_bus_req_t;

endpackage
`default_nettype wire

/* logic/spw_timebase.sv */
// standard pwm timebase with avalon-mm register slave
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`default_nettype none
`include "spw_defs.svh"

module spw_timebase (
    input  wire logic         clock,       // 100 MHz system clock
    input  wire logic         rst_n,       // async reset, active low
    input  wire logic [7:0]   address,     // avalon byte address
    input  wire logic         read,        // avalon read
    input  wire logic         write,       // avalon write
    input  wire logic [3:0]   byteenable,  // avalon byte enables
    input  wire logic [31:0]  writedata,   // avalon write data
    output logic [31:0]       readdata,    // avalon read data
    output logic              waitrequest, // avalon wait
    input  wire logic         sleep_in,    // device sleep request
    output logic              pwm_out,     // output pin level
    output logic              pwm_oe       // output pin driver enable
);
    import spw_pkg::*;

    spw_state_t    r_reg;
    spw_state_t    r_next;
    spw_bus_req_t  bus;
    spw_prescale_t pre;

    logic       req;
    logic       wr_now;
    logic       pwm_mode;
    logic       unit_off;
    logic       tick;
    logic       rollover;
    logic [7:0] pc_last;
    logic [1:0] tb_low;
    logic [9:0] time_base;
    logic [9:0] duty_buf;
    logic [9:0] duty_new;
    logic [7:0] rd_val;

    assign bus = '{read: read, write: write, address: address,
                   byteenable: byteenable, writedata: writedata};

    // one wait cycle lets read data come from a flip-flop
    assign req         = bus.read | bus.write;
    assign waitrequest = req & ~r_reg.ack;
    assign wr_now      = bus.write & r_reg.ack & bus.byteenable[0];
    assign readdata    = {24'h000000, r_reg.rdata};

    assign pwm_out = r_reg.pin_lvl;
    assign pwm_oe  = ~r_reg.pin_dir;

    assign pwm_mode = r_reg.ctrl[`SPW_CTRL_MODE_HI:`SPW_CTRL_MODE_HI - 1]
                      == `SPW_MODE_PWM_TOP;
    assign unit_off = r_reg.ctrl[`SPW_CTRL_MODE_HI:`SPW_CTRL_MODE_LO]
                      == `SPW_MODE_OFF;
    assign pre = spw_prescale_t'(
        r_reg.tctrl[`SPW_TCTRL_PRE_HI:`SPW_TCTRL_PRE_LO]);

    // postscale bits are stored but never consulted here
    always_comb begin
        case (pre)
            spw_pre_1: begin
                pc_last = `SPW_PC_LAST_1;
                tb_low  = r_reg.pc[1:0];
            end
            spw_pre_4: begin
                pc_last = `SPW_PC_LAST_4;
                tb_low  = r_reg.pc[3:2];
            end
            spw_pre_16: begin
                pc_last = `SPW_PC_LAST_16;
                tb_low  = r_reg.pc[5:4];
            end
            spw_pre_64: begin
                pc_last = `SPW_PC_LAST_64;
                tb_low  = r_reg.pc[7:6];
            end
            default: begin
                pc_last = `SPW_PC_LAST_1;
                tb_low  = r_reg.pc[1:0];
            end
        endcase
    end

    // one timer step per 4 x prescale clocks
    assign tick = r_reg.tctrl[`SPW_TCTRL_RUN] & ~r_reg.sleep
                  & (r_reg.pc == pc_last);
    assign rollover  = tick & (r_reg.count == r_reg.period);
    assign time_base = {r_reg.count, tb_low};
    assign duty_buf  = {r_reg.duty_act, r_reg.lsb_latch};
    assign duty_new  = {r_reg.duty_msb,
        r_reg.ctrl[`SPW_CTRL_LSB_HI:`SPW_CTRL_LSB_LO]};

    always_comb begin
        case (bus.address)
            `SPW_OFS_PWM_CONTROL:      rd_val = {2'h0, r_reg.ctrl};
            `SPW_OFS_DUTY_MSB_BYTE:    rd_val = r_reg.duty_msb;
            `SPW_OFS_DUTY_ACTIVE_BYTE: rd_val = r_reg.duty_act;
            `SPW_OFS_TIMER_SELECT:     rd_val = r_reg.tsel;
            `SPW_OFS_PERIOD_LIMIT:     rd_val = r_reg.period;
            `SPW_OFS_TIMEBASE_CONTROL: rd_val = {1'h0, r_reg.tctrl};
            `SPW_OFS_TIMEBASE_COUNT:   rd_val = r_reg.count;
            `SPW_OFS_STATUS:
                rd_val = {6'h00, r_reg.sleep, r_reg.flag};
            `SPW_OFS_PIN_DIRECTION:    rd_val = {7'h00, r_reg.pin_dir};
            default:                   rd_val = 8'h00;
        endcase
    end

    always_comb begin
        r_next = r_reg;

        // three-stage synchroniser, change taken once stages 2 and 3 agree
        r_next.sync = {r_reg.sync[1:0], sleep_in};
        if (r_reg.sync[1] == r_reg.sync[2]) begin
            r_next.sleep = r_reg.sync[2];
        end

        r_next.ack = req & ~r_reg.ack;
        // only reads refresh the data, so readdata stands between reads
        if (bus.read & ~r_reg.ack) begin
            r_next.rdata = rd_val;
        end

        // write one to clear; a rollover in the same cycle wins below
        if (wr_now && bus.address == `SPW_OFS_STATUS
                && bus.writedata[`SPW_STAT_FLAG]) begin
            r_next.flag = 1'b0;
        end

        // prescaler and timer, frozen while asleep
        if (r_reg.tctrl[`SPW_TCTRL_RUN] && !r_reg.sleep) begin
            r_next.pc = tick ? 8'h00 : r_reg.pc + 8'h01;
        end
        if (tick) begin
            r_next.count = rollover ? 8'h00 : r_reg.count + 8'h01;
        end
        if (rollover) begin
            r_next.flag = 1'b1;
        end

        if (unit_off || !pwm_mode) begin
            r_next.pin_lvl = 1'b0;
            if (unit_off) begin
                r_next.duty_act  = `SPW_RST_BYTE;
                r_next.lsb_latch = 2'h0;
            end
        end else if (!r_reg.sleep) begin
            // a match clears; duty above period never matches
            if (time_base == duty_buf) begin
                r_next.pin_lvl = 1'b0;
            end
            if (rollover) begin
                r_next.duty_act  = r_reg.duty_msb;
                r_next.lsb_latch =
                    r_reg.ctrl[`SPW_CTRL_LSB_HI:`SPW_CTRL_LSB_LO];
                r_next.pin_lvl   = (duty_new != 10'h000);
            end
        end

        // register writes take effect at the answering edge
        if (wr_now) begin
            case (bus.address)
                `SPW_OFS_PWM_CONTROL:
                    r_next.ctrl = bus.writedata[5:0];
                `SPW_OFS_DUTY_MSB_BYTE:
                    r_next.duty_msb = bus.writedata[7:0];
                `SPW_OFS_DUTY_ACTIVE_BYTE: begin
                    if (!pwm_mode) begin
                        r_next.duty_act = bus.writedata[7:0];
                    end
                end
                `SPW_OFS_TIMER_SELECT:
                    r_next.tsel = bus.writedata[7:0];
                `SPW_OFS_PERIOD_LIMIT:
                    r_next.period = bus.writedata[7:0];
                `SPW_OFS_TIMEBASE_CONTROL:
                    r_next.tctrl = bus.writedata[6:0];
                `SPW_OFS_TIMEBASE_COUNT: begin
                    // restart the prescaler so the new count gets a full step
                    r_next.count = bus.writedata[7:0];
                    r_next.pc    = 8'h00;
                end
                `SPW_OFS_PIN_DIRECTION:
                    r_next.pin_dir = bus.writedata[0];
                default: begin
                end
            endcase
        end
        if (rollover) begin
            r_next.flag = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_reg.ack       <= 1'b0;
            r_reg.rdata     <= 8'h00;
            r_reg.ctrl      <= `SPW_RST_CTRL;
            r_reg.duty_msb  <= `SPW_RST_BYTE;
            r_reg.duty_act  <= `SPW_RST_BYTE;
            r_reg.lsb_latch <= 2'h0;
            r_reg.tsel      <= `SPW_RST_BYTE;
            r_reg.period    <= `SPW_RST_PERIOD;
            r_reg.tctrl     <= `SPW_RST_TCTRL;
            r_reg.count     <= `SPW_RST_BYTE;
            r_reg.pc        <= 8'h00;
            r_reg.flag      <= 1'b0;
            r_reg.pin_dir   <= `SPW_RST_PIN_DIR;
            r_reg.pin_lvl   <= 1'b0;
            r_reg.sync      <= 3'h0;
            r_reg.sleep     <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

endmodule
`default_nettype wire

/* verification/spw_timebase_chk.sv */
// port assertions of the pwm timebase
`default_nettype none
module spw_timebase_chk (
    input wire logic        clock,       // clock
    input wire logic        rst_n,       // reset
    input wire logic [7:0]  address,     // bus
    input wire logic        read,        // bus
    input wire logic        write,       // bus
    input wire logic [31:0] writedata,   // bus
    input wire logic [31:0] readdata,    // bus
    input wire logic        waitrequest, // bus
    input wire logic        sleep_in,    // sleep
    input wire logic        pwm_out,     // pin
    input wire logic        pwm_oe       // pin enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence req_s; (read || write) && waitrequest; endsequence
    sequence ans_s; (read || write) && !waitrequest; endsequence
    // sleep passes a synchroniser, so allow it to settle
    sequence nap_s; sleep_in [*8]; endsequence
    one_wait_a: assert property (req_s |=> ans_s)
        else $error("bus answer late");
    new_wait_a: assert property (ans_s ##1 (read || write) |-> waitrequest)
        else $error("no wait on back to back request");
    idle_wait_a: assert property (!(read || write) |-> !waitrequest)
        else $error("wait while idle");
    rd_zero_a: assert property (read && !waitrequest
        |-> readdata[31:8] == 24'h0) else $error("read upper bits set");
    rd_hold_a: assert property (!$stable(readdata) |-> read && !waitrequest)
        else $error("read data moved outside answer");
    rst_pin_a: assert property ($rose(rst_n) |-> !pwm_oe && !pwm_out)
        else $error("pin not input after reset");
    nap_hold_a: assert property (nap_s |-> $stable(pwm_out))
        else $error("pin moved in sleep");
    off_low_a: assert property (ans_s ##0 (write && address == 8'h00
        && writedata[3:0] == 4'h0) |-> ##[1:3] !pwm_out)
        else $error("pin high after unit off");
endmodule
bind spw_timebase spw_timebase_chk u_chk (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sleep_in(sleep_in), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe));
`default_nettype wire

/* verification/spw_load_model.sv */
// load on the pwm pin, timing each period seen at the pin
`default_nettype none
module spw_load_model (
    input  wire logic   clock,      // clock
    input  wire logic   rst_n,      // reset
    input  wire logic   pwm_out,    // driven level
    input  wire logic   pwm_oe,     // driver enable
    output logic        meas_valid, // period done
    output logic [31:0] meas        // high and period cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        prev;
    logic        pin;
    logic        rise;
    logic        armed;
    logic [15:0] hcnt;
    logic [15:0] pcnt;
    // no pull on the line, so an undriven pin toggles
    assign pin  = pwm_oe ? pwm_out : ~prev;
    assign rise = pin && !prev;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
            armed <= 1'b0;
            meas_valid <= 1'b0;
            {meas, hcnt, pcnt} <= 64'h0;
        end else begin
            prev <= pin;
            meas_valid <= rise && armed;
            hcnt <= rise ? 16'h1 : hcnt + 16'(pin);
            pcnt <= rise ? 16'h1 : pcnt + 16'h1;
            if (rise) begin
                armed <= pwm_oe;
                meas <= {hcnt, pcnt};
            end
        end
    end
endmodule
`default_nettype wire

/* verification/standard_pwm_timebase_tb_top.sv */
// self-checking bench of the pwm timebase
`default_nettype none
`include "spw_defs.svh"
module standard_pwm_timebase_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic        sleep_in = 1'b0, waitrequest, pwm_out, pwm_oe, meas_valid;
    logic [7:0]  address = 8'h00;
    logic [3:0]  byteenable = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, meas, rd_last;
    logic [31:0] seed = 32'h55e533b1;
    logic [31:0] rq[$], pq[$];
    logic [9:0]  dt;
    int          miscompares = 0, comparisons = 0, p, k, per;
    always #5 clock = ~clock;
    spw_timebase u_dut (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sleep_in(sleep_in),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    spw_load_model u_load (.clock(clock), .rst_n(rst_n), .pwm_out(pwm_out),
        .pwm_oe(pwm_oe), .meas_valid(meas_valid), .meas(meas));
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout(input string what);
        miscompares++;
        $display("mismatch %s expected answer seen timeout", what);
        print_verdict();
    endtask
    task automatic wait_ans();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            if (++n > 50) timeout("bus");
        end while (waitrequest !== 1'b0);
        rd_last = readdata;
    endtask
    task automatic bus_wr(input logic [7:0] a, d);
        @(posedge clock);
        address <= a;
        writedata <= {xorshift() & 32'hffffff00} | 32'(d);
        byteenable <= 4'h1;
        write <= 1'b1;
        wait_ans();
        write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, input logic c, logic [7:0] e);
        @(posedge clock);
        address <= a;
        read <= 1'b1;
        if (c) rq.push_back(32'(e));
        wait_ans();
        read <= 1'b0;
    endtask
    task automatic wait_meas(input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            if (++n > lim) timeout("pwm period");
        end while (meas_valid !== 1'b1);
    endtask
    task automatic pin_hold(input logic e);
        repeat (72) @(posedge clock);
        repeat (24) @(negedge clock) chk("pin", 32'(e), 32'(pwm_out));
    endtask
    // monitors take the oldest expectation when a result shows
    always @(negedge clock)
        if (read && !waitrequest && rq.size() > 0)
            chk("read", rq.pop_front(), readdata);
    always @(negedge clock)
        if (meas_valid && pq.size() > 0)
            chk("pwm timing", pq.pop_front(), meas);
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        bus_wr(8'h24, 8'h5a);
        for (int j = 0; j < 10; j++)
            bus_rd(8'(4 * j), 1'b1, j == 4 ? 8'hff : {7'h0, j == 8});
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            p = 2 + i;
            k = 1 << (2 * i);
            per = (p + 1) * 4 * k;
            dt = 10'(1 + xorshift() % (4 * p + 2));
            bus_wr(`SPW_OFS_PIN_DIRECTION, 8'h01);
            bus_wr(`SPW_OFS_PERIOD_LIMIT, 8'(p));
            bus_wr(`SPW_OFS_PWM_CONTROL, {2'b0, dt[1:0], 2'b11, 2'(i)});
            bus_wr(`SPW_OFS_DUTY_MSB_BYTE, dt[9:2]);
            bus_wr(`SPW_OFS_STATUS, 8'h01);
            bus_wr(`SPW_OFS_TIMEBASE_CONTROL, {1'b0, 4'(5 * i), 1'b1, 2'(i)});
            rd_last = 32'h0;
            for (int n = 0; i != 0 && rd_last[0] !== 1'b1; n++) begin
                if (n > 3000) timeout("flag");
                bus_rd(`SPW_OFS_STATUS, 1'b0, 8'h00);
            end
            bus_wr(`SPW_OFS_PIN_DIRECTION, 8'h00);
            @(negedge clock);
            chk("driver enable", 32'h1, 32'(pwm_oe));
            wait_meas(8 * per);
            @(posedge clock);
            pq.push_back({16'(k * dt + 1), 16'(per)});
            wait_meas(2 * per);
            bus_rd(`SPW_OFS_DUTY_ACTIVE_BYTE, 1'b1, dt[9:2]);
            bus_wr(`SPW_OFS_DUTY_ACTIVE_BYTE, ~dt[9:2]);
            bus_rd(`SPW_OFS_DUTY_ACTIVE_BYTE, 1'b1, dt[9:2]);
            $display("test pwm setting %0d done", i);
        end
        bus_wr(`SPW_OFS_TIMEBASE_CONTROL, 8'h04);
        // prescaler may sit past the new last count; a count write clears it
        bus_wr(`SPW_OFS_TIMEBASE_COUNT, 8'h00);
        bus_wr(`SPW_OFS_PWM_CONTROL, 8'h0c);
        bus_wr(`SPW_OFS_DUTY_MSB_BYTE, 8'h06);
        pin_hold(1'b1);
        bus_wr(`SPW_OFS_DUTY_MSB_BYTE, 8'h00);
        pin_hold(1'b0);
        $display("test duty limits done");
        bus_wr(`SPW_OFS_DUTY_MSB_BYTE, 8'h02);
        @(posedge clock);
        sleep_in <= 1'b1;
        repeat (40) @(posedge clock);
        bus_wr(`SPW_OFS_STATUS, 8'h01);
        bus_rd(`SPW_OFS_STATUS, 1'b1, 8'h02);
        sleep_in <= 1'b0;
        bus_wr(`SPW_OFS_PWM_CONTROL, 8'h00);
        bus_rd(`SPW_OFS_DUTY_ACTIVE_BYTE, 1'b1, 8'h00);
        @(negedge clock);
        chk("pin off", 32'h0, 32'(pwm_out));
        $display("test sleep and off done");
        print_verdict();
    end
endmodule
`default_nettype wire
